// [rtl/ums_regs.vh]
// Register offsets, fields and reset values of the serial line block
`ifndef UMS_REGS_VH
`define UMS_REGS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define UMS_OFF_MODE      12'h000
`define UMS_OFF_CMD       12'h004
`define UMS_OFF_STATUS    12'h008
`define UMS_OFF_TXHOLD    12'h00c
`define UMS_OFF_RXHOLD    12'h010
`define UMS_OFF_DIVISOR   12'h014

// ****************************************************************
// Mode register fields
// ****************************************************************
`define UMS_MODE_FAC_LO   0
`define UMS_MODE_FAC_HI   1
`define UMS_MODE_TXEXT    2
`define UMS_MODE_RXEXT    3
`define UMS_FAC_1X        2'h0
`define UMS_FAC_16X       2'h1
`define UMS_FAC_64X       2'h2

// ****************************************************************
// Command register fields
// ****************************************************************
`define UMS_CMD_TXEN      0
`define UMS_CMD_DTR       1
`define UMS_CMD_RXEN      2
`define UMS_CMD_BREAK     3
`define UMS_CMD_RTS       5

// ****************************************************************
// Status register fields
// ****************************************************************
`define UMS_ST_TXRDY      0
`define UMS_ST_RXRDY      1
`define UMS_ST_TXEMT      2
`define UMS_ST_FRAME      3
`define UMS_ST_OVERRUN    4
`define UMS_ST_CARRIER    6
`define UMS_ST_DATASET    7

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define UMS_RST_MODE      8'h00
`define UMS_RST_CMD       8'h00
`define UMS_RST_DIVISOR   16'h0010
`define UMS_CHAR_BITS     4'ha

`endif

// [rtl/ums_sync.v]
// Two-stage synchroniser for inputs from outside the system clock
`timescale 1ns/1ps

module ums_sync #(
	parameter WIDTH = 1
) (
	// Clock and reset
	input  wire             clk_i,
	input  wire             rst_n_i,
	// Data
	input  wire [WIDTH-1:0] async_i,
	output wire [WIDTH-1:0] sync_o
);

	reg [WIDTH-1:0] meta_r;
	reg [WIDTH-1:0] sync_r;

	// First stage feeds only the second stage
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_r <= {WIDTH{1'b1}};
			sync_r <= {WIDTH{1'b1}};
		end else begin
			meta_r <= async_i;
			sync_r <= meta_r;
		end
	end

	assign sync_o = sync_r;

endmodule // ums_sync

// [rtl/ums_brg.v]
// Baud generator: divides reference clock edges into a 1x bit clock
`timescale 1ns/1ps

module ums_brg (
	// Clock and reset
	input  wire        clk_i,
	input  wire        rst_n_i,
	// Control
	input  wire        run_i,
	input  wire [15:0] half_div_i,
	input  wire        ref_lvl_i,
	// Bit clock
	output wire        bit_clk_o
);

	reg        ref_prev_r;
	reg [15:0] cnt_r;
	reg        clk_r;

	// Idle when unused so the reference may be absent
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ref_prev_r <= 1'b0;
			cnt_r      <= 16'h0000;
			clk_r      <= 1'b1;
		end else begin
			ref_prev_r <= ref_lvl_i;
			if (!run_i) begin
				cnt_r <= 16'h0000;
				clk_r <= 1'b1;
			end else if (ref_lvl_i && !ref_prev_r) begin
				if (cnt_r >= half_div_i - 16'h0001) begin
					cnt_r <= 16'h0000;
					clk_r <= ~clk_r;
				end else begin
					cnt_r <= cnt_r + 16'h0001;
				end
			end
		end
	end

	assign bit_clk_o = clk_r;

endmodule // ums_brg

// [rtl/ums_top.v]
// Serial line pins, modem handshakes and their APB registers
//
// Summary of operation
// R01: External transmit clock at 1x, 16x, 64x
// R02: Transmit data changes on falling clock edges
// R03: Internal transmit clock driven out at 1x
// R04: External receive clock at 1x, 16x, 64x
// R05: Receive data sampled on rising clock edges
// R06: Internal receive clock driven out at 1x
// R07: Receive line high is mark, low space
// R08: Transmit high mark, low space, idle mark
// R09: Receiver works only while carrier input low
// R10: Carrier status bit is inverted carrier input
// R11: Carrier change pulls line-change output low
// R12: Transmitter starts only while clear-to-send low
// R13: Clear-to-send rising lets current character finish
// R14: Data-set status bit is inverted input
// R15: Data-set change pulls line-change output low
// R16: Request-to-send output is inverted command bit
// R17: Terminal-ready output is inverted command bit
// R18: System supplies reference clock for standard rates
// R19: Reference clock unused when both clocks external
// R20: Status read releases output unless transmitter empty
// R21: Handshake outputs follow command within one cycle
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "ums_regs.vh"

module ums_top #(
	parameter [15:0] DIV_RESET = `UMS_RST_DIVISOR
) (
	// Clock and reset
	input  wire        clk_sys_i,
	input  wire        rst_b_i,
	// APB slave
	input  wire        psel_i,
	input  wire        penable_i,
	input  wire        pwrite_i,
	input  wire [11:0] paddr_i,
	input  wire [31:0] pwdata_i,
	output reg  [31:0] prdata_o,
	output wire        pready_o,
	output wire        pslverr_o,
	// Serial data
	input  wire        rx_data_i,
	output wire        tx_data_o,
	// Bit clock pins
	input  wire        transmit_bit_clock_pin_i,
	output wire        transmit_bit_clock_pin_o,
	output wire        transmit_bit_clock_pin_oe_o,
	input  wire        receive_bit_clock_pin_i,
	output wire        receive_bit_clock_pin_o,
	output wire        receive_bit_clock_pin_oe_o,
	input  wire        baud_reference_clock_i,
	// Modem handshakes
	input  wire        carrier_detect_b_i,
	input  wire        clear_to_send_b_i,
	input  wire        data_set_ready_b_i,
	output wire        request_to_send_b_o,
	output wire        terminal_ready_b_o,
	output wire        tx_empty_or_line_change_b_o
);

	// ****************************************************************
	// States and helpers
	// ****************************************************************
	localparam [3:0] RX_IDLE  = 4'h1;
	localparam [3:0] RX_START = 4'h2;
	localparam [3:0] RX_DATA  = 4'h4;
	localparam [3:0] RX_BRK   = 4'h8;
	localparam [1:0] TX_IDLE  = 2'h1;
	localparam [1:0] TX_SHIFT = 2'h2;

	function [6:0] fac_count;
		input [1:0] fac;
		begin
			case (fac)
				`UMS_FAC_16X: fac_count = 7'h10;
				`UMS_FAC_64X: fac_count = 7'h40;
				default:      fac_count = 7'h01;
			endcase
		end
	endfunction

	// ****************************************************************
	// Reset release
	// ****************************************************************
	reg  [1:0] rst_pipe_r;
	wire       rst_n;

	always @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_pipe_r <= 2'h0;
		end else begin
			rst_pipe_r <= {rst_pipe_r[0], 1'b1};
		end
	end
	assign rst_n = rst_pipe_r[1];

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	wire [6:0] pin_s;

	ums_sync #(
		.WIDTH (7)
	) u_sync (
		.clk_i   (clk_sys_i),
		.rst_n_i (rst_n),
		.async_i ({baud_reference_clock_i, receive_bit_clock_pin_i,
			transmit_bit_clock_pin_i, data_set_ready_b_i,
			clear_to_send_b_i, carrier_detect_b_i, rx_data_i}),
		.sync_o  (pin_s)
	);

	wire rxd_s = pin_s[0];
	wire dcd_s = pin_s[1];
	wire cts_s = pin_s[2];
	wire dsr_s = pin_s[3];
	wire txc_s = pin_s[4];
	wire rxc_s = pin_s[5];
	wire ref_s = pin_s[6];

	// ****************************************************************
	// Registers
	// ****************************************************************
	reg  [7:0]  mode_r;
	reg  [7:0]  cmd_r;
	reg  [15:0] div_r;
	reg  [7:0]  thr_r;
	reg         thr_full_r;
	reg  [7:0]  rhr_r;
	reg         rxrdy_r;
	reg         frame_r;
	reg         overrun_r;
	reg         txemt_r;
	reg         change_r;
	reg         dcd_prev_r;
	reg         dsr_prev_r;
	reg  [2:0]  chg_arm_r;

	wire wr_en = psel_i & penable_i & pwrite_i;
	wire rd_en = psel_i & penable_i & ~pwrite_i;
	wire st_rd = rd_en && (paddr_i == `UMS_OFF_STATUS);
	wire rh_rd = rd_en && (paddr_i == `UMS_OFF_RXHOLD);
	wire th_wr = wr_en && (paddr_i == `UMS_OFF_TXHOLD);
	wire hit   = (paddr_i == `UMS_OFF_MODE) ||
		(paddr_i == `UMS_OFF_CMD) || (paddr_i == `UMS_OFF_STATUS) ||
		(paddr_i == `UMS_OFF_TXHOLD) || (paddr_i == `UMS_OFF_RXHOLD) ||
		(paddr_i == `UMS_OFF_DIVISOR);

	assign pready_o  = 1'b1;
	assign pslverr_o = psel_i & penable_i & ~hit;

	wire tx_ext = mode_r[`UMS_MODE_TXEXT];
	wire rx_ext = mode_r[`UMS_MODE_RXEXT];
	wire tx_en  = cmd_r[`UMS_CMD_TXEN];
	wire rx_en  = cmd_r[`UMS_CMD_RXEN];
	wire [6:0] fac_n = fac_count(mode_r[`UMS_MODE_FAC_HI:`UMS_MODE_FAC_LO]);

	// ****************************************************************
	// Internal bit clock
	// ****************************************************************
	wire int_clk;

	ums_brg u_brg (
		.clk_i      (clk_sys_i),
		.rst_n_i    (rst_n),
		.run_i      (~(tx_ext & rx_ext)), // see R18 // see R19
		.half_div_i (div_r),
		.ref_lvl_i  (ref_s),
		.bit_clk_o  (int_clk)
	);

	assign transmit_bit_clock_pin_o    = int_clk; // see R03
	assign transmit_bit_clock_pin_oe_o = ~tx_ext;
	assign receive_bit_clock_pin_o     = int_clk; // see R06
	assign receive_bit_clock_pin_oe_o  = ~rx_ext;

	// Internal clocks are already 1x, external ones divide by factor
	wire [6:0] tx_n = tx_ext ? fac_n : 7'h01; // see R01
	wire [6:0] rx_n = rx_ext ? fac_n : 7'h01; // see R04
	wire tx_lvl = tx_ext ? txc_s : int_clk;
	wire rx_lvl = rx_ext ? rxc_s : int_clk;
	reg  tx_lvl_prev_r;
	reg  rx_lvl_prev_r;
	wire tx_edge = ~tx_lvl & tx_lvl_prev_r; // see R02
	wire rx_edge = rx_lvl & ~rx_lvl_prev_r; // see R05

	// ****************************************************************
	// Transmitter
	// ****************************************************************
	reg [1:0] tx_st_r;
	reg [6:0] tx_pre_r;
	reg [3:0] tx_bits_r;
	reg [9:0] tx_sh_r;
	reg       txd_r;
	reg       tx_load;
	reg       tx_done;

	wire tx_ok = tx_en & ~cts_s & thr_full_r; // see R12

	always @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			tx_lvl_prev_r <= 1'b1;
			tx_st_r       <= TX_IDLE;
			tx_pre_r      <= 7'h00;
			tx_bits_r     <= 4'h0;
			tx_sh_r       <= 10'h3ff;
			txd_r         <= 1'b1;
			tx_load       <= 1'b0;
			tx_done       <= 1'b0;
		end else begin
			tx_lvl_prev_r <= tx_lvl;
			tx_load       <= 1'b0;
			tx_done       <= 1'b0;
			if (tx_edge) begin
				if (tx_pre_r != 7'h00) begin
					tx_pre_r <= tx_pre_r - 7'h01;
				end else begin
					tx_pre_r <= tx_n - 7'h01;
					case (tx_st_r)
						TX_IDLE: begin
							if (tx_ok) begin
								txd_r     <= 1'b0;
								tx_sh_r   <= {1'b1, thr_r, 1'b0};
								tx_bits_r <= `UMS_CHAR_BITS - 4'h1;
								tx_load   <= 1'b1;
								tx_st_r   <= TX_SHIFT;
							end else begin
								txd_r <= 1'b1; // see R08
							end
						end
						TX_SHIFT: begin
							// Character finishes even if CTS has risen
							if (tx_bits_r != 4'h0) begin
								txd_r     <= tx_sh_r[1]; // see R13
								tx_sh_r   <= {1'b1, tx_sh_r[9:1]};
								tx_bits_r <= tx_bits_r - 4'h1;
							end else if (tx_ok) begin
								txd_r     <= 1'b0;
								tx_sh_r   <= {1'b1, thr_r, 1'b0};
								tx_bits_r <= `UMS_CHAR_BITS - 4'h1;
								tx_load   <= 1'b1;
							end else begin
								txd_r   <= 1'b1;
								tx_done <= 1'b1;
								tx_st_r <= TX_IDLE;
							end
						end
						default: begin
							txd_r   <= 1'b1;
							tx_st_r <= TX_IDLE;
						end
					endcase
				end
			end
		end
	end

	// Break forces space while transmit is enabled; mark otherwise when disabled and idle
	assign tx_data_o = txd_r & ~(cmd_r[`UMS_CMD_BREAK] & tx_en); // see R08

	// ****************************************************************
	// Receiver
	// ****************************************************************
	reg [3:0] rx_st_r;
	reg [6:0] rx_cnt_r;
	reg [3:0] rx_bits_r;
	reg [7:0] rx_sh_r;
	reg       rx_put;
	reg       rx_ferr;

	wire rx_ok = rx_en & ~dcd_s; // see R09

	always @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			rx_lvl_prev_r <= 1'b1;
			rx_st_r       <= RX_IDLE;
			rx_cnt_r      <= 7'h00;
			rx_bits_r     <= 4'h0;
			rx_sh_r       <= 8'h00;
			rx_put        <= 1'b0;
			rx_ferr       <= 1'b0;
		end else begin
			rx_lvl_prev_r <= rx_lvl;
			rx_put        <= 1'b0;
			rx_ferr       <= 1'b0;
			if (!rx_ok) begin
				rx_st_r <= RX_IDLE;
			end else if (rx_edge) begin
				case (rx_st_r)
					RX_IDLE: begin
						// Low is space, so a low sample is a start bit
						if (!rxd_s) begin // see R07
							rx_bits_r <= 4'h0;
							if (rx_n == 7'h01) begin
								rx_cnt_r <= 7'h00;
								rx_st_r  <= RX_DATA;
							end else begin
								rx_cnt_r <= (rx_n >> 1) - 7'h02;
								rx_st_r  <= RX_START;
							end
						end
					end
					RX_START: begin
						if (rx_cnt_r != 7'h00) begin
							rx_cnt_r <= rx_cnt_r - 7'h01;
						end else if (!rxd_s) begin
							rx_cnt_r <= rx_n - 7'h01;
							rx_st_r  <= RX_DATA;
						end else begin
							rx_st_r <= RX_IDLE;
						end
					end
					RX_DATA: begin
						if (rx_cnt_r != 7'h00) begin
							rx_cnt_r <= rx_cnt_r - 7'h01;
						end else begin
							rx_cnt_r <= rx_n - 7'h01;
							if (rx_bits_r == `UMS_CHAR_BITS - 4'h2) begin
								rx_put  <= 1'b1;
								rx_ferr <= ~rxd_s;
								rx_st_r <= rxd_s ? RX_IDLE : RX_BRK;
							end else begin
								rx_sh_r   <= {rxd_s, rx_sh_r[7:1]};
								rx_bits_r <= rx_bits_r + 4'h1;
							end
						end
					end
					RX_BRK: begin
						// Line must return to mark before next start
						if (rxd_s) begin
							rx_st_r <= RX_IDLE;
						end
					end
					default: rx_st_r <= RX_IDLE;
				endcase
			end
		end
	end

	// ****************************************************************
	// Register writes and status flags
	// ****************************************************************
	// Masked until the synchronisers hold real pin levels, no false change
	wire line_chg = chg_arm_r[2] &
		((dcd_s ^ dcd_prev_r) | (dsr_s ^ dsr_prev_r));

	always @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			mode_r     <= `UMS_RST_MODE;
			cmd_r      <= `UMS_RST_CMD;
			div_r      <= DIV_RESET;
			thr_r      <= 8'h00;
			thr_full_r <= 1'b0;
			rhr_r      <= 8'h00;
			rxrdy_r    <= 1'b0;
			frame_r    <= 1'b0;
			overrun_r  <= 1'b0;
			txemt_r    <= 1'b0;
			change_r   <= 1'b0;
			dcd_prev_r <= 1'b1;
			dsr_prev_r <= 1'b1;
			chg_arm_r  <= 3'h0;
		end else begin
			chg_arm_r  <= {chg_arm_r[1:0], 1'b1};
			dcd_prev_r <= dcd_s;
			dsr_prev_r <= dsr_s;
			if (wr_en && paddr_i == `UMS_OFF_MODE) begin
				mode_r <= pwdata_i[7:0];
			end
			if (wr_en && paddr_i == `UMS_OFF_CMD) begin
				cmd_r <= pwdata_i[7:0]; // see R21
			end
			if (wr_en && paddr_i == `UMS_OFF_DIVISOR) begin
				div_r <= (pwdata_i[15:0] == 16'h0000) ? 16'h0001 :
					pwdata_i[15:0];
			end
			// Hardware sets win over software clears
			if (th_wr) begin
				thr_r      <= pwdata_i[7:0];
				thr_full_r <= 1'b1;
				txemt_r    <= 1'b0; // see R20
			end else if (tx_load) begin
				thr_full_r <= 1'b0;
			end
			if (tx_done) begin
				txemt_r <= 1'b1;
			end
			if (line_chg) begin
				change_r <= 1'b1; // see R11 // see R15
			end else if (st_rd) begin
				change_r <= 1'b0; // see R20
			end
			if (rx_put) begin
				rhr_r     <= rx_sh_r;
				rxrdy_r   <= 1'b1;
				frame_r   <= rx_ferr;
				overrun_r <= rxrdy_r & ~rh_rd;
			end else if (rh_rd) begin
				rxrdy_r <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Read mux and modem outputs
	// ****************************************************************
	always @* begin
		prdata_o = 32'h00000000;
		case (paddr_i)
			`UMS_OFF_MODE:    prdata_o[7:0]  = mode_r;
			`UMS_OFF_CMD:     prdata_o[7:0]  = cmd_r;
			`UMS_OFF_TXHOLD:  prdata_o[7:0]  = thr_r;
			`UMS_OFF_RXHOLD:  prdata_o[7:0]  = rhr_r;
			`UMS_OFF_DIVISOR: prdata_o[15:0] = div_r;
			`UMS_OFF_STATUS: begin
				prdata_o[`UMS_ST_TXRDY]   = ~thr_full_r & tx_en;
				prdata_o[`UMS_ST_RXRDY]   = rxrdy_r;
				prdata_o[`UMS_ST_TXEMT]   = txemt_r | change_r;
				prdata_o[`UMS_ST_FRAME]   = frame_r;
				prdata_o[`UMS_ST_OVERRUN] = overrun_r;
				prdata_o[`UMS_ST_CARRIER] = ~dcd_s; // see R10
				prdata_o[`UMS_ST_DATASET] = ~dsr_s; // see R14
			end
			default: prdata_o = 32'h00000000;
		endcase
	end

	assign request_to_send_b_o = ~cmd_r[`UMS_CMD_RTS]; // see R16
	assign terminal_ready_b_o  = ~cmd_r[`UMS_CMD_DTR]; // see R17
	assign tx_empty_or_line_change_b_o = ~(txemt_r | change_r); // see R11

endmodule // ums_top

// [test/ums_modem_model.sv]
// Modem model: external 1x bit clock, receive source, transmit capture
`timescale 1ns/1ps

module ums_modem_model #(
	parameter int HALF_NS = 100
) (
	// Link side
	output logic      link_clk_o,
	output logic      rx_line_o,
	input  wire logic tx_line_i
);
	logic [11:0] tx_seen;

	// Clock rests high between frames, line rests at mark
	initial begin
		link_clk_o = 1'b1;
		rx_line_o = 1'b1;
		tx_seen = 12'hfff;
	end

	// Twelve bit periods; data moves on the fall so it is settled at the rise
	task automatic frame(input logic [7:0] b);
		logic [11:0] seq;
		seq = {3'b111, b, 1'b0};
		#7;
		for (int i = 0; i < 12; i++) begin
			link_clk_o = 1'b0;
			rx_line_o = seq[i];
			#(HALF_NS);
			link_clk_o = 1'b1;
			#(HALF_NS - 5);
			tx_seen[i] = tx_line_i;
			#5;
		end
	endtask
endmodule // ums_modem_model

// [test/ums_top_props.sv]
// Port checker for the serial line block
`timescale 1ns/1ps
`include "ums_regs.vh"

module ums_top_props (
	// Clock, reset and bus
	input wire logic        clk_sys_i,
	input wire logic        rst_b_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic        pready_o,
	// Line side
	input wire logic        tx_data_o,
	input wire logic        transmit_bit_clock_pin_i,
	input wire logic        transmit_bit_clock_pin_o,
	input wire logic        transmit_bit_clock_pin_oe_o,
	input wire logic        receive_bit_clock_pin_oe_o,
	input wire logic        carrier_detect_b_i,
	input wire logic        data_set_ready_b_i,
	input wire logic        request_to_send_b_o,
	input wire logic        terminal_ready_b_o,
	input wire logic        tx_empty_or_line_change_b_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);

	wire wr_v = psel_i && penable_i && pready_o && pwrite_i;
	wire cmd_w = wr_v && paddr_i == `UMS_OFF_CMD;
	wire mode_w = wr_v && paddr_i == `UMS_OFF_MODE;
	wire st_rd = psel_i && penable_i && pready_o && !pwrite_i
		&& paddr_i == `UMS_OFF_STATUS;
	wire transmit_bit_clock_pin = transmit_bit_clock_pin_oe_o ? transmit_bit_clock_pin_o
		: transmit_bit_clock_pin_i;
	logic [3:0] dcd_age_r;
	logic [3:0] dsr_age_r;
	logic [3:0] fall_age_r;
	logic       brk_r;

	function automatic logic [3:0] sat(input logic [3:0] a);
		return (a == 4'hf) ? a : a + 4'h1;
	endfunction

	// Ages let status be judged only once the synchronisers have settled
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			dcd_age_r <= 4'h0;
			dsr_age_r <= 4'h0;
			fall_age_r <= 4'hf;
			brk_r <= 1'b0;
		end else begin
			dcd_age_r <= $changed(carrier_detect_b_i) ? 4'h0 : sat(dcd_age_r);
			dsr_age_r <= $changed(data_set_ready_b_i) ? 4'h0 : sat(dsr_age_r);
			fall_age_r <= $fell(transmit_bit_clock_pin) ? 4'h0 : sat(fall_age_r);
			if (cmd_w) begin
				brk_r <= pwdata_i[`UMS_CMD_BREAK] & pwdata_i[`UMS_CMD_TXEN];
			end
		end
	end

	property p_rts;
		cmd_w |=> request_to_send_b_o == !$past(pwdata_i[`UMS_CMD_RTS]);
	endproperty
	a_rts: assert property (p_rts) else $error("rts wrong");
	property p_dtr;
		cmd_w |=> terminal_ready_b_o == !$past(pwdata_i[`UMS_CMD_DTR]);
	endproperty
	a_dtr: assert property (p_dtr) else $error("dtr wrong");
	property p_dcd_st;
		st_rd && dcd_age_r > 4'h5 |-> prdata_o[6] == !carrier_detect_b_i;
	endproperty
	a_dcd_st: assert property (p_dcd_st) else $error("bit 6 wrong");
	property p_dsr_st;
		st_rd && dsr_age_r > 4'h5 |-> prdata_o[7] == !data_set_ready_b_i;
	endproperty
	a_dsr_st: assert property (p_dsr_st) else $error("bit 7 wrong");
	property p_dcd_chg;
		$changed(carrier_detect_b_i) |-> ##[1:6] !tx_empty_or_line_change_b_o;
	endproperty
	a_dcd_chg: assert property (p_dcd_chg) else $error("no dcd flag");
	property p_dsr_chg;
		$changed(data_set_ready_b_i) |-> ##[1:6] !tx_empty_or_line_change_b_o;
	endproperty
	a_dsr_chg: assert property (p_dsr_chg) else $error("no dsr flag");
	property p_tx_edge;
		$changed(tx_data_o) && $stable(brk_r) |-> fall_age_r < 4'h7;
	endproperty
	a_tx_edge: assert property (p_tx_edge) else $error("tx off edge");
	property p_txoe;
		mode_w |=> transmit_bit_clock_pin_oe_o
			== !$past(pwdata_i[`UMS_MODE_TXEXT]);
	endproperty
	a_txoe: assert property (p_txoe) else $error("tx pin dir");
	property p_rxoe;
		mode_w |=> receive_bit_clock_pin_oe_o
			== !$past(pwdata_i[`UMS_MODE_RXEXT]);
	endproperty
	a_rxoe: assert property (p_rxoe) else $error("rx pin dir");

	c_st_rd: cover property (st_rd);
	c_flag: cover property ($fell(tx_empty_or_line_change_b_o));
	c_start: cover property ($fell(tx_data_o));
endmodule // ums_top_props

bind ums_top ums_top_props u_props (
	.clk_sys_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
	.pwdata_i, .prdata_o, .pready_o, .tx_data_o,
	.transmit_bit_clock_pin_i, .transmit_bit_clock_pin_o,
	.transmit_bit_clock_pin_oe_o, .receive_bit_clock_pin_oe_o,
	.carrier_detect_b_i, .data_set_ready_b_i, .request_to_send_b_o,
	.terminal_ready_b_o, .tx_empty_or_line_change_b_o
);

// [test/uart_modem_and_serial_clock_pins_tb.sv]
// Testbench for the serial line block
`timescale 1ns/1ps
`include "ums_regs.vh"

module uart_modem_and_serial_clock_pins_tb;
	logic        clk_sys_i, rst_b_i, psel_i, penable_i, pwrite_i;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, rd;
	logic        pready_o, pslverr_o, rx_data_i, tx_data_o, err, lk;
	logic        txc_o, txc_oe, rxc_o, rxc_oe;
	logic        bref = 1'b0, ref_on = 1'b0, pt, pr;
	logic        carrier_detect_b_i, clear_to_send_b_i, data_set_ready_b_i;
	logic        request_to_send_b_o, terminal_ready_b_o;
	logic        tx_empty_or_line_change_b_o;
	logic [7:0]  cmdv [4] = '{8'h22, 8'h20, 8'h02, 8'h00};
	int          compares, miscompares, nt, nr;
	wire         lc = tx_empty_or_line_change_b_o;
	// Shared pins: whoever has the enable drives
	wire         txc_pin = txc_oe ? txc_o : lk;
	wire         rxc_pin = rxc_oe ? rxc_o : lk;
	wire [31:0]  hs = {30'h0, request_to_send_b_o, terminal_ready_b_o};
	wire [31:0]  pins = {26'h0, tx_data_o, hs[1:0], lc, txc_oe, rxc_oe};

	ums_top #(.DIV_RESET(16'h0002)) dut (
		.clk_sys_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
		.pwdata_i, .prdata_o, .pready_o, .pslverr_o, .rx_data_i, .tx_data_o,
		.transmit_bit_clock_pin_i(txc_pin),
		.transmit_bit_clock_pin_o(txc_o),
		.transmit_bit_clock_pin_oe_o(txc_oe),
		.receive_bit_clock_pin_i(rxc_pin),
		.receive_bit_clock_pin_o(rxc_o),
		.receive_bit_clock_pin_oe_o(rxc_oe),
		.baud_reference_clock_i(bref),
		.carrier_detect_b_i, .clear_to_send_b_i, .data_set_ready_b_i,
		.request_to_send_b_o, .terminal_ready_b_o, .tx_empty_or_line_change_b_o
	);
	ums_modem_model modem (.link_clk_o(lk), .rx_line_o(rx_data_i),
		.tx_line_i(tx_data_o));

	task automatic final_report;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, got);
		compares++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
			miscompares++;
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask

	task automatic settle;
		@(negedge clk_sys_i);
	endtask

	// One APB transfer; pready is awaited, never assumed
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_sys_i);
		penable_i <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (pready_o !== 1'b1 && n < 20);
		if (pready_o !== 1'b1) begin
			miscompares++;
			final_report();
		end
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask

	// The start bit is allowed to land on the first, second or third fall
	task automatic chk_tx(input logic [7:0] b);
		int k;
		k = 0;
		while (k < 2 && modem.tx_seen[k] !== 1'b0) k++;
		chk("tx frame", {22'h0, 1'b1, b, 1'b0}, {22'h0, modem.tx_seen[k +: 10]});
	endtask

	initial begin
		clk_sys_i = 1'b0;
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end

	// Reference runs only once the internal clocks are wanted
	initial begin
		forever #98.645 bref = ref_on & ~bref;
	end

	initial begin
		#200000;
		miscompares++;
		final_report();
	end

	initial begin
		{rst_b_i, psel_i, penable_i, pwrite_i} = 4'h0;
		paddr_i = 12'h000;
		pwdata_i = 32'h0;
		{carrier_detect_b_i, clear_to_send_b_i, data_set_ready_b_i} = 3'h0;
		cyc(12);
		rst_b_i <= 1'b1;
		cyc(3);
		settle();
		chk("idle pins", 32'h3f, pins);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, `UMS_OFF_CMD, {24'h0, cmdv[i]});
			settle();
			chk("rts dtr", {30'h0, ~cmdv[i][5], ~cmdv[i][1]}, hs);
		end
		apb(1'b1, `UMS_OFF_MODE, 32'h0000000c);
		settle();
		chk("clk oe", 32'h0, {30'h0, txc_oe, rxc_oe});
		apb(1'b0, 12'h0fc, 32'h0);
		chk("unmapped", 32'h1, {31'h0, err});
		apb(1'b0, `UMS_OFF_STATUS, 32'h0);
		chk("status", 32'h3, {30'h0, rd[7:6]});
		for (int i = 0; i < 2; i++) begin
			@(posedge clk_sys_i);
			if (i == 0) data_set_ready_b_i <= 1'b1;
			else carrier_detect_b_i <= 1'b1;
			cyc(8);
			chk("change", 32'h0, {31'h0, lc});
			apb(1'b0, `UMS_OFF_STATUS, 32'h0);
			chk("status", {31'h0, i == 0}, {30'h0, rd[7:6]});
			settle();
			chk("release", 32'h1, {31'h0, lc});
		end
		@(posedge clk_sys_i);
		carrier_detect_b_i <= 1'b0;
		cyc(8);
		apb(1'b0, `UMS_OFF_STATUS, 32'h0);
		// Loopback frame in both directions at once
		apb(1'b1, `UMS_OFF_CMD, 32'h5);
		apb(1'b1, `UMS_OFF_TXHOLD, 32'ha5);
		modem.frame(8'h3c);
		chk_tx(8'ha5);
		apb(1'b0, `UMS_OFF_STATUS, 32'h0);
		settle();
		chk("rx ready", 32'h1, {31'h0, rd[1]});
		chk("txemt hold", 32'h0, {31'h0, lc});
		apb(1'b0, `UMS_OFF_RXHOLD, 32'h0);
		chk("rx data", 32'h3c, rd);
		apb(1'b1, `UMS_OFF_TXHOLD, 32'h96);
		settle();
		chk("load release", 32'h1, {31'h0, lc});
		// Handshakes withheld: nothing may leave or arrive
		@(posedge clk_sys_i);
		clear_to_send_b_i <= 1'b1;
		carrier_detect_b_i <= 1'b1;
		cyc(8);
		modem.frame(8'h00);
		chk("cts held", 32'hfff, {20'h0, modem.tx_seen});
		apb(1'b0, `UMS_OFF_STATUS, 32'h0);
		chk("rx off", 32'h0, {31'h0, rd[1]});
		@(posedge clk_sys_i);
		clear_to_send_b_i <= 1'b0;
		cyc(8);
		fork
			modem.frame(8'hff);
			begin
				cyc(30);
				clear_to_send_b_i <= 1'b1;
			end
		join
		chk_tx(8'h96);
		// Internal clocks: a bit spans four reference periods, six rises
		ref_on <= 1'b1;
		apb(1'b1, `UMS_OFF_MODE, 32'h0);
		nt = 0;
		nr = 0;
		pt = txc_pin;
		pr = rxc_pin;
		repeat (200) begin
			@(posedge clk_sys_i);
			if (txc_pin && !pt) nt++;
			if (rxc_pin && !pr) nr++;
			pt = txc_pin;
			pr = rxc_pin;
		end
		chk("tx int clk", 32'h6, nt);
		chk("rx int clk", 32'h6, nr);
		apb(1'b1, `UMS_OFF_CMD, 32'h9);
		settle();
		chk("break", 32'h0, {31'h0, tx_data_o});
		apb(1'b1, `UMS_OFF_CMD, 32'h8);
		settle();
		chk("tx off mark", 32'h1, {31'h0, tx_data_o});
		final_report();
	end
endmodule // uart_modem_and_serial_clock_pins_tb
